// [hdl/scm_top.sv]
`timescale 1ns/1ps

// How it works
// - each channel shifts through 8 bits and buffers the byte in its data low byte
// - three units, channels 0 to 3 in units 0 and 1, 0 to 1 in unit 2, own operation setting per channel
// - operation setting is 16 bits and resets to 0x0087
// - bits 15 and 14 pick off, receive only, transmit only or both
// - bits 13 and 12 pick the clock edge that launches and samples, msb first
// - bit 10 clear: error irq masked; set: an overrun raises the error irq instead of the receive irq
// - a spurious error irq on a clocked channel is tolerated
// - writing one to a start bit sets the matching enable status bit
// - writing one to a stop bit clears the matching enable status bit
// - enabled channel ignores software clock level, pin follows communication
// - stopped channel drives the software clock level onto the pin
// - enable status is read only, whole word or low byte
// - enable status resets to zero, bits 15 to 4 read zero
module scm_top
    import scm_pkg::*;
(
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic ce,
    input wire logic [31:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [NCH-1:0] sck_in,
    input wire logic [NCH-1:0] si,
    output logic [NCH-1:0] sck_out,
    output logic [NCH-1:0] so_out,
    output logic irq
);

    // ------------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------------
    logic [15:0] scr [NCH];
    logic [15:0] sdr [NCH];
    logic [7:0] rx_sh [NCH];
    logic [7:0] tx_sh [NCH];
    logic [2:0] bit_cnt [NCH];
    logic [NCH-1:0] rx_full;
    logic [NCH-1:0] se;
    logic [NCH-1:0] cko;
    logic [NCH-1:0] sck_s1;
    logic [NCH-1:0] sck_s2;
    logic [NCH-1:0] sck_s3;
    logic [NCH-1:0] si_s1;
    logic [NCH-1:0] si_s2;
    logic [31:0] irq_stat;
    logic [31:0] irq_en;

    // ------------------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------------------
    scm_apb_req_s req;
    logic [19:0] idx;
    logic in_range;
    logic wr_fire;
    logic rd_fire;
    logic setup;
    logic [15:0] wmask16;

    always_comb begin
        req.addr = paddr;
        req.write = pwrite;
        req.wdata = pwdata;
        req.strb = pstrb;
    end

    // the word index only means something for aligned addresses in the low 4 mb
    assign idx = req.addr[21:2];
    assign in_range = (req.addr[31:22] == 10'h000) && (req.addr[1:0] == 2'h0);
    assign setup = psel && !penable;
    // a write lands at the single edge where the access phase meets pready
    assign wr_fire = psel && penable && pready && req.write && ce;
    assign rd_fire = psel && penable && pready && !req.write && ce;
    assign wmask16 = {{8{req.strb[1]}}, {8{req.strb[0]}}};

    function automatic logic hit(input logic [19:0] a, input logic [19:0] target);
        return a == target;
    endfunction

    // ------------------------------------------------------------------------
    // per-unit strobes and channel modes
    // ------------------------------------------------------------------------
    logic [NCH-1:0] start_req;
    logic [NCH-1:0] stop_req;
    logic [NCH-1:0] so_wr;
    logic [NCH-1:0] scr_wr;
    logic [NCH-1:0] sdr_wr;
    logic [NCH-1:0] sdr_rd;
    scm_mode_s mode [NCH];

    always_comb begin
        for (int c = 0; c < NCH; c++) begin
            automatic int u = unit_of(c);
            automatic int n = local_of(c);
            automatic logic [19:0] se_i = se_idx_of(u);
            mode[c] = mode_of(scr[c]);
            scr_wr[c] = wr_fire && in_range && hit(idx, scr_idx_of(c));
            sdr_wr[c] = wr_fire && in_range && hit(idx, SDR_IDX + 20'(2 * c));
            sdr_rd[c] = rd_fire && in_range && hit(idx, SDR_IDX + 20'(2 * c));
            // strobes exist only while the write completes, nothing is stored
            start_req[c] = wr_fire && in_range && hit(idx, se_i + SS_OFS)
                && req.strb[0] && req.wdata[n];
            stop_req[c] = wr_fire && in_range && hit(idx, se_i + ST_OFS)
                && req.strb[0] && req.wdata[n];
            so_wr[c] = wr_fire && in_range && hit(idx, se_i + SO_OFS) && req.strb[1];
        end
    end

    // ------------------------------------------------------------------------
    // link input synchronisers
    // ------------------------------------------------------------------------
    // sck_s3 only delays sck_s2, so edges are found on settled samples
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            sck_s1 <= '0;
            sck_s2 <= '0;
            sck_s3 <= '0;
            si_s1 <= '0;
            si_s2 <= '0;
        end else if (ce) begin
            sck_s1 <= sck_in;
            sck_s2 <= sck_s1;
            sck_s3 <= sck_s2;
            si_s1 <= si;
            si_s2 <= si_s1;
        end
    end

    // ------------------------------------------------------------------------
    // clock phase decode
    // ------------------------------------------------------------------------
    logic [NCH-1:0] sample_ev;
    logic [NCH-1:0] launch_ev;
    logic [NCH-1:0] byte_done;
    logic [NCH-1:0] overrun;
    logic [NCH-1:0] rx_irq_ev;
    logic [NCH-1:0] err_irq_ev;
    logic [7:0] next_byte [NCH];

    always_comb begin
        for (int c = 0; c < NCH; c++) begin
            automatic logic eff = sck_s2[c] ^ mode[c].ckp;
            automatic logic eff_prev = sck_s3[c] ^ mode[c].ckp;
            automatic logic rise = eff && !eff_prev;
            automatic logic fall = !eff && eff_prev;
            automatic logic active = se[c] && (mode[c].txe || mode[c].rxe);
            // polarity flips the line, phase swaps which edge samples
            sample_ev[c] = active && (mode[c].dap ? fall : rise);
            launch_ev[c] = active && (mode[c].dap ? rise : fall);
            next_byte[c] = {rx_sh[c][6:0], si_s2[c]};
            byte_done[c] = sample_ev[c] && (bit_cnt[c] == 3'h7);
            overrun[c] = byte_done[c] && mode[c].rxe && rx_full[c];
            // an unmasked error replaces the receive event; a clocked channel
            // left with bit 10 set may raise it too and that is accepted
            err_irq_ev[c] = overrun[c] && mode[c].eoc;
            rx_irq_ev[c] = byte_done[c] && !err_irq_ev[c];
        end
    end

    // ------------------------------------------------------------------------
    // operation setting registers
    // ------------------------------------------------------------------------
    // reserved bits are never stored so they always read zero
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            for (int c = 0; c < NCH; c++) begin
                scr[c] <= SCR_RESET;
            end
        end else if (ce) begin
            for (int c = 0; c < NCH; c++) begin
                if (scr_wr[c]) begin
                    // all fields, including framing ones, held as plain bits
                    scr[c] <= (scr[c] & ~(wmask16 & SCR_WMASK))
                        | (req.wdata[15:0] & wmask16 & SCR_WMASK);
                end
            end
        end
    end

    // ------------------------------------------------------------------------
    // enable status
    // ------------------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            se <= NCH'(SE_RESET);
        end else if (ce) begin
            for (int c = 0; c < NCH; c++) begin
                if (stop_req[c]) begin
                    se[c] <= 1'b0;
                end else if (start_req[c]) begin
                    se[c] <= 1'b1;
                end
            end
        end
    end

    // ------------------------------------------------------------------------
    // serial output register and clock pins
    // ------------------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            cko <= '1;
        end else if (ce) begin
            for (int c = 0; c < NCH; c++) begin
                // a running channel owns its clock level, software is ignored
                if (so_wr[c] && !se[c]) begin
                    cko[c] <= req.wdata[8 + local_of(c)];
                end
            end
        end
    end

    // the pin follows the link while running, the software level while stopped
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            sck_out <= '1;
        end else if (ce) begin
            for (int c = 0; c < NCH; c++) begin
                sck_out[c] <= se[c] ? sck_s2[c] : cko[c];
            end
        end
    end

    // ------------------------------------------------------------------------
    // shift and buffer datapath
    // ------------------------------------------------------------------------
    // bus reads of a full buffer empty it; a byte arriving in that same
    // cycle keeps it full, so the new byte is not lost
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            for (int c = 0; c < NCH; c++) begin
                sdr[c] <= SDR_RESET;
                rx_sh[c] <= 8'h00;
                tx_sh[c] <= 8'h00;
                bit_cnt[c] <= 3'h0;
            end
            rx_full <= '0;
        end else if (ce) begin
            for (int c = 0; c < NCH; c++) begin
                if (!se[c]) begin
                    bit_cnt[c] <= 3'h0;
                end else if (sample_ev[c]) begin
                    rx_sh[c] <= next_byte[c];
                    bit_cnt[c] <= bit_cnt[c] + 3'h1;
                end
                if (sdr_wr[c]) begin
                    sdr[c] <= (sdr[c] & ~wmask16) | (req.wdata[15:0] & wmask16);
                    if (req.strb[0]) begin
                        tx_sh[c] <= req.wdata[7:0];
                    end
                end else if (launch_ev[c] && mode[c].txe) begin
                    tx_sh[c] <= {tx_sh[c][6:0], 1'b0};
                end
                if (byte_done[c] && mode[c].rxe) begin
                    sdr[c][7:0] <= next_byte[c];
                    rx_full[c] <= 1'b1;
                end else if (sdr_rd[c]) begin
                    rx_full[c] <= 1'b0;
                end
            end
        end
    end

    // idle line is high; only transmitting channels put data out
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            so_out <= '1;
        end else if (ce) begin
            for (int c = 0; c < NCH; c++) begin
                so_out[c] <= (se[c] && mode[c].txe) ? tx_sh[c][7] : 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------------
    // interrupt status, enable and output
    // ------------------------------------------------------------------------
    logic [31:0] irq_set;
    logic [31:0] irq_clr;

    always_comb begin
        irq_set = '0;
        irq_set[NCH-1:0] = rx_irq_ev;
        irq_set[IRQ_ERR_POS +: NCH] = err_irq_ev;
        irq_clr = (wr_fire && in_range && hit(idx, IRQ_CLR_IDX)) ? req.wdata : 32'h0000_0000;
    end

    // set beats clear when both arrive together
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            irq_stat <= IRQ_RESET;
        end else if (ce) begin
            irq_stat <= (irq_stat & ~irq_clr) | irq_set;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            irq_en <= IRQ_RESET;
        end else if (ce && wr_fire && in_range && hit(idx, IRQ_EN_IDX)) begin
            irq_en <= req.wdata;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            irq <= 1'b0;
        end else if (ce) begin
            irq <= |(irq_stat & irq_en);
        end
    end

    // ------------------------------------------------------------------------
    // read mux and bus answer
    // ------------------------------------------------------------------------
    logic [31:0] next_prdata;
    logic next_err;

    always_comb begin
        next_prdata = 32'h0000_0000;
        next_err = 1'b1;
        if (in_range) begin
            for (int c = 0; c < NCH; c++) begin
                if (hit(idx, scr_idx_of(c))) begin
                    next_prdata = {16'h0000, scr[c]};
                    next_err = 1'b0;
                end
                if (hit(idx, SDR_IDX + 20'(2 * c))) begin
                    next_prdata = {16'h0000, sdr[c]};
                    next_err = 1'b0;
                end
            end
            for (int u = 0; u < NUNIT; u++) begin
                automatic logic [19:0] se_i = se_idx_of(u);
                if (hit(idx, se_i)) begin
                    // upper twelve bits always zero; the low byte is the alias
                    for (int n = 0; n < CH_PER_UNIT; n++) begin
                        if (u * CH_PER_UNIT + n < NCH) begin
                            next_prdata[n] = se[u * CH_PER_UNIT + n];
                        end
                    end
                    next_err = 1'b0;
                end
                if (hit(idx, se_i + SO_OFS)) begin
                    for (int n = 0; n < CH_PER_UNIT; n++) begin
                        if (u * CH_PER_UNIT + n < NCH) begin
                            next_prdata[8 + n] = cko[u * CH_PER_UNIT + n];
                        end
                    end
                    next_err = 1'b0;
                end
                // trigger registers are write only and read as zero
                if (hit(idx, se_i + SS_OFS) || hit(idx, se_i + ST_OFS)) begin
                    next_err = 1'b0;
                end
            end
            if (hit(idx, IRQ_STAT_IDX)) begin
                next_prdata = irq_stat;
                next_err = 1'b0;
            end
            if (hit(idx, IRQ_EN_IDX)) begin
                next_prdata = irq_en;
                next_err = 1'b0;
            end
            if (hit(idx, IRQ_CLR_IDX)) begin
                next_err = 1'b0;
            end
        end
        // enable status cannot be written; treat a write there as an error
        for (int u = 0; u < NUNIT; u++) begin
            if (in_range && req.write && hit(idx, se_idx_of(u))) begin
                next_err = 1'b1;
            end
        end
    end

    // one wait-free access phase: answer raised the cycle after setup
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else if (ce) begin
            if (setup) begin
                pready <= 1'b1;
                pslverr <= next_err;
                prdata <= req.write ? 32'h0000_0000 : next_prdata;
            end else begin
                pready <= 1'b0;
                pslverr <= 1'b0;
            end
        end
    end

endmodule

// [inc/scm_pkg.sv]
// ----------------------------------------------------------------------------
// serial channel mode and enable: shared constants and types
// ----------------------------------------------------------------------------
package scm_pkg;

    // ------------------------------------------------------------------------
    // array shape
    // ------------------------------------------------------------------------
    localparam int NUNIT = 3;
    localparam int NCH = 10;            // units 0,1 carry four channels, unit 2 two
    localparam int CH_PER_UNIT = 4;
    localparam int SHIFT_BITS = 8;

    // ------------------------------------------------------------------------
    // register indices (byte address = 4 * index)
    // ------------------------------------------------------------------------
    localparam logic [19:0] U0_SCR_IDX = 20'hf0118;  // chan0_unit0_operation_setting
    localparam logic [19:0] U0_SCR3_IDX = 20'hf011e; // chan3_unit0_operation_setting
    localparam logic [19:0] U0_SE_IDX = 20'hf0120;   // unit0_channel_enable_status
    localparam logic [19:0] U1_SCR_IDX = 20'hf0158;  // chan0_unit1_operation_setting
    localparam logic [19:0] U1_SCR3_IDX = 20'hf015e; // chan3_unit1_operation_setting
    localparam logic [19:0] U1_SE_IDX = 20'hf0160;   // unit1_channel_enable_status
    localparam logic [19:0] U2_SCR_IDX = 20'hf020c;  // chan0_unit2_operation_setting
    localparam logic [19:0] U2_SCR1_IDX = 20'hf020e; // chan1_unit2_operation_setting
    localparam logic [19:0] U2_SE_IDX = 20'hf0210;   // unit2_channel_enable_status
    localparam logic [19:0] SCR_STEP = 20'h00002;
    // per-unit trigger and output registers, placed after enable status
    localparam logic [19:0] SS_OFS = 20'h00002;      // channel_start_trigger
    localparam logic [19:0] ST_OFS = 20'h00004;      // channel_stop_trigger
    localparam logic [19:0] SO_OFS = 20'h00006;      // serial_output_reg
    // per-channel serial data and the interrupt block
    localparam logic [19:0] SDR_IDX = 20'hf0300;     // + 2 * channel
    localparam logic [19:0] IRQ_STAT_IDX = 20'hf0320;
    localparam logic [19:0] IRQ_EN_IDX = 20'hf0322;
    localparam logic [19:0] IRQ_CLR_IDX = 20'hf0324;

    // ------------------------------------------------------------------------
    // operation setting fields and reset values
    // ------------------------------------------------------------------------
    localparam int TXE_POS = 15;
    localparam int RXE_POS = 14;
    localparam int DAP_POS = 13;
    localparam int CKP_POS = 12;
    localparam int EOC_POS = 10;
    localparam logic [15:0] SCR_RESET = 16'h0087;
    localparam logic [15:0] SCR_WMASK = 16'hf7b7;    // bits 11, 6, 3 read zero
    localparam logic [15:0] SE_RESET = 16'h0000;
    localparam logic [15:0] SDR_RESET = 16'h0000;
    localparam logic [3:0] SO_RESET = 4'hf;          // clock lines idle high
    localparam logic [31:0] IRQ_RESET = 32'h0000_0000;
    localparam int IRQ_ERR_POS = 16;                 // error bits at 16 + channel

    // ------------------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------------------
    typedef struct packed {
        logic [31:0] addr;
        logic write;
        logic [31:0] wdata;
        logic [3:0] strb;
    } scm_apb_req_s;

    typedef struct packed {
        logic txe;
        logic rxe;
        logic dap;
        logic ckp;
        logic eoc;
    } scm_mode_s;

    // ------------------------------------------------------------------------
    // channel to unit mapping
    // ------------------------------------------------------------------------
    function automatic int unit_of(input int c);
        return c / CH_PER_UNIT;
    endfunction

    function automatic int local_of(input int c);
        return c % CH_PER_UNIT;
    endfunction

    function automatic logic [19:0] scr_idx_of(input int c);
        logic [19:0] base;
        base = (unit_of(c) == 0) ? U0_SCR_IDX : (unit_of(c) == 1) ? U1_SCR_IDX : U2_SCR_IDX;
        return base + SCR_STEP * 20'(local_of(c));
    endfunction

    function automatic logic [19:0] se_idx_of(input int u);
        return (u == 0) ? U0_SE_IDX : (u == 1) ? U1_SE_IDX : U2_SE_IDX;
    endfunction

    function automatic scm_mode_s mode_of(input logic [15:0] scr);
        scm_mode_s m;
        m.txe = scr[TXE_POS];
        m.rxe = scr[RXE_POS];
        m.dap = scr[DAP_POS];
        m.ckp = scr[CKP_POS];
        m.eoc = scr[EOC_POS];
        return m;
    endfunction

endpackage

// [tb/scm_asserts.sv]
`timescale 1ns/1ps
// ----------------------------------------------------------------------------
// bus answer and clock pin checks
// ----------------------------------------------------------------------------
module scm_asserts
    import scm_pkg::*;
(
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic [31:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [NCH-1:0] sck_in,
    input wire logic [NCH-1:0] sck_out
);
    localparam logic [31:0] SE0_A = {10'h000, U0_SE_IDX, 2'b00};
    wire logic setup = psel && !penable;
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_b);
    // zero wait states, so every setup must be answered on the next edge
    ans_next_a: assert property (setup |=> pready)
        else $error("setup not answered");
    ans_once_a: assert property (pready |=> !pready)
        else $error("answer longer than one cycle");
    err_with_a: assert property (pslverr |-> pready)
        else $error("error without answer");
    err_unmap_a: assert property (setup && paddr >= 32'h0040_0000 |=> pslverr)
        else $error("unmapped access not refused");
    se_ro_a: assert property (setup && pwrite && paddr == SE0_A |=> pslverr)
        else $error("enable status write accepted");
    se_high_a: assert property (setup && !pwrite && paddr == SE0_A |=> !(|prdata[15:4]))
        else $error("enable status upper bits set");
    // a write setup zeroes the read data, a cycle without a setup leaves it alone
    rd_hold_a: assert property (!setup |=> $stable(prdata))
        else $error("read data moved without a setup");
    wr_zero_a: assert property (setup && pwrite |=> prdata == 32'h0000_0000)
        else $error("read data not zero after a write");
    // five quiet cycles cover the sync delay, so the pin may not move
    clk_hold_a: assert property (($stable(sck_in[0]) && !psel) [*5] |-> $stable(sck_out[0]))
        else $error("clock pin moved without cause");
endmodule
bind scm_top scm_asserts u_chk (.mclk(mclk), .rst_b(rst_b), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sck_in(sck_in), .sck_out(sck_out));

// [tb/scm_link_model.sv]
`timescale 1ns/1ps
// ----------------------------------------------------------------------------
// serial peripheral on channel 0, type 1 phase
// ----------------------------------------------------------------------------
module scm_link_model (
    input wire logic so,
    output logic sck,
    output logic sd,
    output logic [7:0] got
);
    // clock stands high between frames; data sampled before each falling edge
    task automatic frame(input logic [7:0] b);
        #7;
        for (int i = 7; i >= 0; i--) begin
            got = {got[6:0], so};
            sck = 1'b0;
            sd = b[i];
            #80 sck = 1'b1;
            #80;
        end
        sd = ~sd; // no pull, so the released line shows no stale bit
    endtask
    initial begin
        sck = 1'b1;
        sd = 1'b1;
        got = 8'h00;
    end
endmodule

// [tb/scm_top_tb_top.sv]
`timescale 1ns/1ps
// ----------------------------------------------------------------------------
// register bank bench
// ----------------------------------------------------------------------------
module scm_top_tb_top
    import scm_pkg::*;
;
    logic mclk = 1'b0, rst_b = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata;
    logic pready, pslverr, irq, lk_sck, lk_sd;
    logic [NCH-1:0] sck_out, so_out;
    logic [8:0] rn = 9'h000;
    logic [16:0] lf = 17'h12bfd;
    logic [15:0] v;
    logic [7:0] got;
    logic [17:0] nt;
    logic [17:0] q[$];
    int n_errors = 0, total_checks = 0;
    scm_top u_dut (.mclk(mclk), .rst_b(rst_b), .ce(1'b1), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(4'h3), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .sck_in({rn, lk_sck}), .si({rn, lk_sd}),
        .sck_out(sck_out), .so_out(so_out), .irq(irq));
    scm_link_model u_link (.so(so_out[0]), .sck(lk_sck), .sd(lk_sd), .got(got));
    initial forever #10 mclk = ~mclk;
    function automatic logic [31:0] ba(input logic [19:0] i);
        return {10'h000, i, 2'b00};
    endfunction
    function automatic logic [16:0] lfsr(input logic [16:0] s);
        return {s[15:0], s[16] ^ s[13]};
    endfunction
    // idle channels see noise on their pins
    always @(posedge mclk) begin
        lf <= lfsr(lf);
        rn <= lf[8:0];
    end
    task automatic chk(input string nm, input logic [15:0] s, input logic [15:0] e);
        total_checks++;
        if (s !== e) begin
            n_errors++;
            $display("unexpected %s: expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic print_verdict;
        if (n_errors == 0 && total_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // note bits: 17 read, 16 error, 15:0 data
    task automatic bus(input logic [31:0] a, input logic w, input logic [15:0] d, input logic [17:0] n);
        @(posedge mclk);
        q.push_back(n);
        paddr <= a;
        pwrite <= w;
        pwdata <= {16'h0000, d};
        psel <= 1'b1;
        @(posedge mclk);
        penable <= 1'b1;
        do @(posedge mclk); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [31:0] a, input logic [15:0] d, input logic e);
        bus(a, 1'b1, d, {1'b0, e, 16'h0000});
    endtask
    task automatic rd(input logic [31:0] a, input logic [15:0] e);
        bus(a, 1'b0, 16'h0000, {2'b10, e});
    endtask
    // pins are registered after the write lands, so look a cycle later
    task automatic pin;
        repeat (2) @(negedge mclk);
    endtask
    // answers are matched against the oldest note
    always @(posedge mclk) if (psel && penable && pready === 1'b1) begin
        nt = q.pop_front();
        chk("pslverr", {15'h0000, pslverr}, {15'h0000, nt[16]});
        if (nt[17]) chk("prdata", prdata[15:0], nt[15:0]);
    end
    initial begin
        repeat (5) @(posedge mclk);
        rst_b <= 1'b1;
        for (int c = 0; c < NCH; c++) rd(ba(scr_idx_of(c)), 16'h0087);
        for (int u = 0; u < NUNIT; u++) rd(ba(se_idx_of(u)), 16'h0000);
        wr(ba(U0_SE_IDX), 16'h000f, 1'b1);
        wr(32'h0040_0000, 16'h0001, 1'b1);
        rd(ba(U0_SE_IDX), 16'h0000);
        for (int c = 1; c < NCH; c++) begin
            v = (lf[15:0] & 16'hf7b3) | 16'h0004;
            wr(ba(scr_idx_of(c)), v, 1'b0);
            rd(ba(scr_idx_of(c)), v);
        end
        wr(ba(U0_SCR_IDX), 16'hc007, 1'b0);
        wr(ba(IRQ_EN_IDX), 16'h0001, 1'b0);
        wr(ba(U0_SE_IDX + SS_OFS), 16'h0001, 1'b0);
        rd(ba(U0_SE_IDX), 16'h0001);
        wr(ba(U0_SE_IDX + SO_OFS), 16'h0000, 1'b0);
        pin();
        chk("sck_out", {14'h0000, sck_out[1:0]}, 16'h0001);
        wr(ba(SDR_IDX), 16'h00a5, 1'b0);
        @(posedge mclk);
        u_link.frame(8'h3c);
        for (int k = 0; k < 20 && irq !== 1'b1; k++) @(posedge mclk);
        chk("irq", {15'h0000, irq}, 16'h0001);
        chk("got", {8'h00, got}, 16'h00a5);
        rd(ba(SDR_IDX), 16'h003c);
        rd(ba(IRQ_STAT_IDX), 16'h0001);
        wr(ba(IRQ_EN_IDX), 16'h0000, 1'b0);
        pin();
        chk("irq", {15'h0000, irq}, 16'h0000);
        wr(ba(IRQ_EN_IDX), 16'h0001, 1'b0);
        pin();
        chk("irq", {15'h0000, irq}, 16'h0001);
        wr(ba(IRQ_CLR_IDX), 16'h0001, 1'b0);
        pin();
        chk("irq", {15'h0000, irq}, 16'h0000);
        wr(ba(U0_SE_IDX + ST_OFS), 16'h0001, 1'b0);
        rd(ba(U0_SE_IDX), 16'h0000);
        pin();
        chk("sck_out", {14'h0000, sck_out[1:0]}, 16'h0001);
        wr(ba(U0_SE_IDX + SO_OFS), 16'h0000, 1'b0);
        pin();
        chk("sck_out", {14'h0000, sck_out[1:0]}, 16'h0000);
        print_verdict();
    end
    // a hung handshake ends the run as a failure
    initial begin
        #100000;
        n_errors++;
        print_verdict();
    end
endmodule
